//--- design/vams_top.sv
// address mode and attribute selection with translation and debug tags
`timescale 1ns/10ps
`include "vams_defines.svh"
module vams_top #(
	parameter int TLB_N = 32,
	parameter int TLB_IW = 5
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [1:0] req_kind_i,
	input wire logic req_special_i,
	input wire logic supervisor_flag_i,
	input wire logic [7:0] address_space_tag_i,
	input wire logic translation_enable_i,
	input wire logic [31:0] translation_window_base_i,
	input wire logic [1:0][31:0] sram_window_base_i,
	input wire logic [3:0][31:0] access_window_reg_i,
	input wire logic [31:0] cache_default_ctrl_i,
	input wire logic tlb_wr_i,
	input wire logic tlb_rd_i,
	input wire logic [TLB_IW-1:0] tlb_idx_i,
	input wire logic [31:0] tlb_tag_i,
	input wire logic [31:0] tlb_data_i,
	input wire logic [3:0][39:0] pc_bkpt_i,
	input wire logic [3:0] pc_bkpt_tag_en_i,
	input wire logic [39:0] data_bkpt_i,
	input wire logic data_bkpt_tag_en_i,
	input wire logic cof_valid_i,
	input wire logic cof_indirect_i,
	input wire logic [31:0] cof_target_i,
	input wire logic trace_tag_en_i,
	input wire logic pc_resync_request_i,
	input wire logic [31:0] cur_pc_i,
	output logic resp_valid_o,
	output logic [31:0] resp_paddr_o,
	output logic [6:0] resp_set_o,
	output logic resp_virtual_o,
	output logic [2:0] resp_src_o,
	output logic [1:0] resp_cm_o,
	output logic resp_wp_o,
	output logic resp_fault_o,
	output logic [3:0] fault_status_code_o,
	output logic [31:0] fault_addr_o,
	output logic [31:0] tlb_rtag_o,
	output logic [31:0] tlb_rdata_o,
	output logic [3:0] pc_bkpt_hit_o,
	output logic data_bkpt_hit_o,
	output logic trace_valid_o,
	output logic [39:0] trace_addr_o
);
	typedef struct packed {
		logic resp_valid;
		logic [31:0] paddr;
		logic [6:0] set;
		logic virt;
		vams_pkg::vams_src_t src;
		logic [1:0] cm;
		logic wp;
		logic fault;
		logic [3:0] fs;
		logic [31:0] faddr;
		logic [3:0] pc_hit;
		logic d_hit;
		logic trace_valid;
		logic [39:0] trace_addr;
	} vams_top_st_t;

	vams_top_st_t s_r;
	vams_top_st_t s_nxt;
	vams_tlb_if #(.IW(TLB_IW)) tlb ();
	logic is_i;
	logic is_super;
	logic tw_hit;
	logic [1:0] sw_hit;
	logic [3:0] aw_hit;
	logic [1:0] aw_sel;
	logic go_tlb;
	logic viol;
	logic [21:0] pm;
	logic [39:0] full_addr;
	vams_pkg::vams_entry_t te;

	// tagged compare shared by code and data breakpoints
	function automatic logic vams_bkpt_match(input logic [39:0] bref, input logic use_tag,
		input logic [39:0] a);
		vams_bkpt_match = bref[31:0] == a[31:0] && (!use_tag || bref[39:32] == a[39:32]);
	endfunction

	////////////////////////////////////////////////////////////////
	// entry store, loaded and read only through the indirect port
	vams_tlb_mem #(.N(TLB_N), .IW(TLB_IW)) u_mem (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.tlb(tlb.mem)
	);

	assign tlb.look_vpn = req_addr_i[`VAMS_VPN];
	assign tlb.look_tag = address_space_tag_i;
	assign tlb.look_instr = is_i;
	assign tlb.wr = tlb_wr_i;
	assign tlb.rd = tlb_rd_i;
	assign tlb.idx = tlb_idx_i;
	assign tlb.wtag = tlb_tag_i;
	assign tlb.wdata = tlb_data_i;

	// four access windows: pair 0/1 serves data, pair 2/3 serves fetches
	genvar gw;
	generate
		for (gw = 0; gw < 4; gw++) begin : g_aw
			vams_win_hit u_aw (
				.addr_i(req_addr_i),
				.win_i(access_window_reg_i[gw]),
				.super_i(is_super),
				.hit_o(aw_hit[gw])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// kept out of the decode process: is_i feeds the store and is_super the windows, which feed it back
	assign is_i = req_kind_i == `VAMS_KIND_IFETCH || req_kind_i == `VAMS_KIND_IEXT;
	assign is_super = supervisor_flag_i;

	// window decode, all within the request cycle
	always_comb begin
		tw_hit = translation_enable_i && translation_window_base_i[`VAMS_TW_VALID] &&
			!is_i && is_super &&
			req_addr_i[`VAMS_TW_BASE] == translation_window_base_i[`VAMS_TW_BASE];
		for (int k = 0; k < 2; k++) begin
			sw_hit[k] = sram_window_base_i[k][`VAMS_SW_VALID] &&
				req_addr_i[`VAMS_SW_BASE] == sram_window_base_i[k][`VAMS_SW_BASE];
		end
		aw_sel = is_i ? aw_hit[3:2] : aw_hit[1:0];
		go_tlb = !req_special_i && translation_enable_i && !tw_hit && !(|sw_hit) &&
			!(|aw_sel);
		te = tlb.hit_entry;
		pm = vams_pkg::vams_page_mask(te.size);
		// a supervisor-only page refuses user code; kind picks the needed right
		viol = (te.sp && !is_super) || (is_i && !te.x) ||
			(req_kind_i == `VAMS_KIND_DREAD && !te.r) ||
			(req_kind_i == `VAMS_KIND_DWRITE && !te.w);
		full_addr = {address_space_tag_i, req_addr_i};
	end

	////////////////////////////////////////////////////////////////
	// answer resolution; the answer registers one edge after the request
	always_comb begin
		s_nxt = s_r;
		s_nxt.resp_valid = req_valid_i;
		s_nxt.trace_valid = 1'b0;
		s_nxt.pc_hit = 4'h0;
		s_nxt.d_hit = 1'b0;
		s_nxt.fault = 1'b0; // pulses with the answer, so the pin needs no gating
		if (req_valid_i) begin
			s_nxt.paddr = req_addr_i;
			s_nxt.set = req_addr_i[`VAMS_SET];
			s_nxt.virt = 1'b0;
			s_nxt.fault = 1'b0;
			s_nxt.fs = `VAMS_FS_NONE;
			s_nxt.wp = 1'b0;
			s_nxt.cm = `VAMS_CM_NOCACHE;
			if (req_special_i) begin
				s_nxt.src = vams_pkg::VAMS_SRC_SPECIAL;
			end else if (tw_hit) begin
				s_nxt.src = vams_pkg::VAMS_SRC_TWIN;
			end else if (|sw_hit) begin
				s_nxt.src = vams_pkg::VAMS_SRC_SRAM;
				s_nxt.wp = sw_hit[0] ? sram_window_base_i[0][`VAMS_SW_WP] :
					sram_window_base_i[1][`VAMS_SW_WP];
			end else if (|aw_sel) begin
				s_nxt.src = vams_pkg::VAMS_SRC_AWIN;
				s_nxt.cm = aw_sel[0] ? access_window_reg_i[{is_i, 1'b0}][`VAMS_AW_CM] :
					access_window_reg_i[{is_i, 1'b1}][`VAMS_AW_CM];
				s_nxt.wp = aw_sel[0] ? access_window_reg_i[{is_i, 1'b0}][`VAMS_AW_WP] :
					access_window_reg_i[{is_i, 1'b1}][`VAMS_AW_WP];
			end else if (!go_tlb) begin
				// only reached with translation off; defaults then apply
				s_nxt.src = vams_pkg::VAMS_SRC_PHYS;
				s_nxt.cm = cache_default_ctrl_i[`VAMS_CD_CM];
				s_nxt.wp = cache_default_ctrl_i[`VAMS_CD_WP];
			end else begin
				s_nxt.src = vams_pkg::VAMS_SRC_TLB;
				s_nxt.virt = 1'b1;
				if (!tlb.hit) begin
					s_nxt.fault = 1'b1;
					s_nxt.faddr = req_addr_i;
					case (req_kind_i)
						`VAMS_KIND_IFETCH: s_nxt.fs = `VAMS_FS_MISS_IFETCH;
						`VAMS_KIND_IEXT: s_nxt.fs = `VAMS_FS_MISS_IEXT;
						`VAMS_KIND_DREAD: s_nxt.fs = `VAMS_FS_MISS_DREAD;
						default: s_nxt.fs = `VAMS_FS_MISS_DWRITE;
					endcase
				end else if (viol) begin
					s_nxt.fault = 1'b1;
					s_nxt.faddr = req_addr_i;
					s_nxt.fs = `VAMS_FS_VIOL;
				end else begin
					// page-number bits outside the page mask come back untranslated from the virtual address
					s_nxt.paddr = {(te.ppn & pm) | (req_addr_i[`VAMS_VPN] & ~pm),
						req_addr_i[`VAMS_INPAGE]};
					s_nxt.cm = te.cm;
					s_nxt.wp = te.wp;
				end
			end
			for (int b = 0; b < 4; b++) begin
				s_nxt.pc_hit[b] = is_i && vams_bkpt_match(pc_bkpt_i[b], pc_bkpt_tag_en_i[b],
					full_addr);
			end
			s_nxt.d_hit = !is_i && vams_bkpt_match(data_bkpt_i, data_bkpt_tag_en_i,
				full_addr);
		end
		// resync outranks flow trace in the same cycle
		if (pc_resync_request_i) begin
			s_nxt.trace_valid = 1'b1;
			s_nxt.trace_addr = {address_space_tag_i, cur_pc_i};
		end else if (cof_valid_i && cof_indirect_i) begin
			s_nxt.trace_valid = 1'b1;
			s_nxt.trace_addr = {trace_tag_en_i ? address_space_tag_i : 8'h00,
				cof_target_i};
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from the state register or the store's read register
	assign resp_valid_o = s_r.resp_valid;
	assign resp_paddr_o = s_r.paddr;
	assign resp_set_o = s_r.set;
	assign resp_virtual_o = s_r.virt;
	assign resp_src_o = s_r.src;
	assign resp_cm_o = s_r.cm;
	assign resp_wp_o = s_r.wp;
	assign resp_fault_o = s_r.fault;
	assign fault_status_code_o = s_r.fs;
	assign fault_addr_o = s_r.faddr;
	assign tlb_rtag_o = tlb.rtag;
	assign tlb_rdata_o = tlb.rdata;
	assign pc_bkpt_hit_o = s_r.pc_hit;
	assign data_bkpt_hit_o = s_r.d_hit;
	assign trace_valid_o = s_r.trace_valid;
	assign trace_addr_o = s_r.trace_addr;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	a_special_phys: assert property (
		req_valid_i && req_special_i |=> resp_valid_o && !resp_virtual_o &&
		resp_paddr_o == $past(req_addr_i) && resp_cm_o == `VAMS_CM_NOCACHE)
		else $error("special request not physical");
	a_off_phys: assert property (
		req_valid_i && !translation_enable_i |=> !resp_virtual_o && !resp_fault_o &&
		resp_paddr_o == $past(req_addr_i))
		else $error("request translated while disabled");
	a_twin_first: assert property (
		req_valid_i && !req_special_i && tw_hit |=> resp_src_o == vams_pkg::VAMS_SRC_TWIN)
		else $error("translation window lost priority");
	a_window_phys: assert property (
		req_valid_i && !req_special_i && (|sw_hit) |=> !resp_virtual_o &&
		resp_paddr_o == $past(req_addr_i) && resp_src_o != vams_pkg::VAMS_SRC_AWIN)
		else $error("window hit translated");
	a_nohit_virtual: assert property (
		req_valid_i && go_tlb |=> resp_virtual_o && resp_src_o == vams_pkg::VAMS_SRC_TLB)
		else $error("unmapped request not virtual");
	a_no_default: assert property (
		req_valid_i && translation_enable_i |=> resp_src_o != vams_pkg::VAMS_SRC_PHYS)
		else $error("default attributes used while translating");
	a_twin_super: assert property (
		resp_valid_o && resp_src_o == vams_pkg::VAMS_SRC_TWIN |->
		$past(supervisor_flag_i) && $past(req_kind_i[1]))
		else $error("translation window reached by user or fetch");
	a_miss_fault: assert property (
		req_valid_i && go_tlb && !tlb.hit |=> resp_fault_o &&
		fault_status_code_o != `VAMS_FS_VIOL && fault_addr_o == $past(req_addr_i))
		else $error("lookup miss without fault");
	a_inpage_pass: assert property (
		resp_valid_o && resp_virtual_o |-> resp_paddr_o[9:0] == $past(req_addr_i[9:0]))
		else $error("in-page offset altered");
	a_set_virtual: assert property (
		req_valid_i |=> resp_set_o == $past(req_addr_i[10:4]))
		else $error("set index not untranslated");
	a_resync_pc: assert property (
		pc_resync_request_i |=> trace_valid_o &&
		trace_addr_o == {$past(address_space_tag_i), $past(cur_pc_i)})
		else $error("resync without full tagged pc");
endmodule

//--- design/vams_defines.svh
// constants for the virtual address mode select block
`ifndef VAMS_DEFINES_SVH
`define VAMS_DEFINES_SVH
// request kinds
`define VAMS_KIND_IFETCH 2'h0
`define VAMS_KIND_IEXT 2'h1
`define VAMS_KIND_DREAD 2'h2
`define VAMS_KIND_DWRITE 2'h3
// fault status codes
`define VAMS_FS_NONE 4'h0
`define VAMS_FS_MISS_IFETCH 4'h5
`define VAMS_FS_MISS_IEXT 4'h6
`define VAMS_FS_MISS_DREAD 4'h9
`define VAMS_FS_MISS_DWRITE 4'ha
`define VAMS_FS_VIOL 4'hc
// access window register fields
`define VAMS_AW_BASE 31:24
`define VAMS_AW_MASK 23:16
`define VAMS_AW_FBASE 23:20
`define VAMS_AW_FMASK 19:16
`define VAMS_AW_EN 15
`define VAMS_AW_PRIV 14:13
`define VAMS_AW_AMM 10
`define VAMS_AW_CM 6:5
`define VAMS_AW_WP 2
`define VAMS_PRIV_USER 2'h0
`define VAMS_PRIV_SUPER 2'h1
// translation and sram window fields
`define VAMS_TW_BASE 31:16
`define VAMS_TW_VALID 0
`define VAMS_SW_BASE 31:12
`define VAMS_SW_WP 8
`define VAMS_SW_VALID 0
// default cache control fields
`define VAMS_CD_CM 9:8
`define VAMS_CD_WP 5
`define VAMS_CM_NOCACHE 2'h2
// address split and cache set bits
`define VAMS_VPN 31:10
`define VAMS_INPAGE 9:0
`define VAMS_SET 10:4
// indirect entry word layout
`define VAMS_T_VPN 31:10
`define VAMS_T_TAG 9:2
`define VAMS_T_VALID 1
`define VAMS_T_INSTR 0
`define VAMS_D_PPN 31:10
`define VAMS_D_SIZE 9:8
`define VAMS_D_CM 7:6
`define VAMS_D_SP 5
`define VAMS_D_R 4
`define VAMS_D_W 3
`define VAMS_D_X 2
`define VAMS_D_WP 1
// page sizes and compared page-number bits
`define VAMS_PG_1K 2'h0
`define VAMS_PG_4K 2'h1
`define VAMS_PG_8K 2'h2
`define VAMS_PMASK_1K 22'h3fffff
`define VAMS_PMASK_4K 22'h3ffffc
`define VAMS_PMASK_8K 22'h3ffff8
`define VAMS_PMASK_1M 22'h3ffc00
`endif

//--- design/vams_pkg.sv
// types and shared decode for the address mode select block
`include "vams_defines.svh"
package vams_pkg;
	typedef struct packed {
		logic valid;
		logic instr;
		logic [7:0] tag;
		logic [21:0] vpn;
		logic [21:0] ppn;
		logic [1:0] size;
		logic [1:0] cm;
		logic sp;
		logic r;
		logic w;
		logic x;
		logic wp;
	} vams_entry_t;

	typedef enum logic [2:0] {
		VAMS_SRC_NONE,
		VAMS_SRC_SPECIAL,
		VAMS_SRC_PHYS,
		VAMS_SRC_TWIN,
		VAMS_SRC_SRAM,
		VAMS_SRC_AWIN,
		VAMS_SRC_TLB
	} vams_src_t;

	// page-number bits that take part in the compare
	function automatic logic [21:0] vams_page_mask(input logic [1:0] size);
		case (size)
			`VAMS_PG_1K: vams_page_mask = `VAMS_PMASK_1K;
			`VAMS_PG_4K: vams_page_mask = `VAMS_PMASK_4K;
			`VAMS_PG_8K: vams_page_mask = `VAMS_PMASK_8K;
			default: vams_page_mask = `VAMS_PMASK_1M;
		endcase
	endfunction
endpackage

//--- design/vams_tlb_if.sv
// lookup and maintenance signals between top and entry store
`timescale 1ns/10ps
interface vams_tlb_if #(parameter int IW = 5);
	logic [21:0] look_vpn;
	logic [7:0] look_tag;
	logic look_instr;
	logic hit;
	vams_pkg::vams_entry_t hit_entry;
	logic wr;
	logic rd;
	logic [IW-1:0] idx;
	logic [31:0] wtag;
	logic [31:0] wdata;
	logic [31:0] rtag;
	logic [31:0] rdata;
	modport mem (input look_vpn, look_tag, look_instr, wr, rd, idx, wtag, wdata,
		output hit, hit_entry, rtag, rdata);
	modport user (output look_vpn, look_tag, look_instr, wr, rd, idx, wtag, wdata,
		input hit, hit_entry, rtag, rdata);
endinterface

//--- design/vams_win_hit.sv
// access window hit function
`timescale 1ns/10ps
`include "vams_defines.svh"
module vams_win_hit (
	input wire logic [31:0] addr_i,
	input wire logic [31:0] win_i,
	input wire logic super_i,
	output logic hit_o
);
	logic priv_ok;
	logic [7:0] m;
	logic [3:0] fm;

	// privilege field gates the window, so user code cannot reach supervisor space
	always_comb begin
		m = win_i[`VAMS_AW_MASK];
		fm = win_i[`VAMS_AW_FMASK];
		case (win_i[`VAMS_AW_PRIV])
			`VAMS_PRIV_USER: priv_ok = !super_i;
			`VAMS_PRIV_SUPER: priv_ok = super_i;
			default: priv_ok = 1'b1;
		endcase
		hit_o = 1'b0;
		if (win_i[`VAMS_AW_EN] && priv_ok) begin
			if (win_i[`VAMS_AW_AMM]) begin
				hit_o = (addr_i[`VAMS_AW_BASE] == win_i[`VAMS_AW_BASE]) &&
					((addr_i[`VAMS_AW_FBASE] & ~fm) == (win_i[`VAMS_AW_FBASE] & ~fm));
			end else begin
				hit_o = (addr_i[`VAMS_AW_BASE] & ~m) == (win_i[`VAMS_AW_BASE] & ~m);
			end
		end
	end
endmodule

//--- design/vams_tlb_mem.sv
// software-loaded translation entry store with parallel lookup
`timescale 1ns/10ps
`include "vams_defines.svh"
module vams_tlb_mem #(
	parameter int N = 32,
	parameter int IW = 5
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	vams_tlb_if.mem tlb
);
	typedef struct packed {
		vams_pkg::vams_entry_t [N-1:0] ent;
		logic [31:0] rtag;
		logic [31:0] rdata;
	} vams_mem_st_t;

	vams_mem_st_t s_r;
	vams_mem_st_t s_nxt;
	logic [N-1:0] match;
	vams_pkg::vams_entry_t e;

	////////////////////////////////////////////////////////////////
	// every entry compares at once; no stall on a hit
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_cmp
			assign match[gi] = s_r.ent[gi].valid && s_r.ent[gi].instr == tlb.look_instr &&
				s_r.ent[gi].tag == tlb.look_tag &&
				((s_r.ent[gi].vpn ^ tlb.look_vpn) &
				vams_pkg::vams_page_mask(s_r.ent[gi].size)) == 22'h000000;
		end
	endgenerate

	// lowest matching index wins if software loaded duplicates
	always_comb begin
		tlb.hit = 1'b0;
		tlb.hit_entry = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (match[i]) begin
				tlb.hit = 1'b1;
				tlb.hit_entry = s_r.ent[i];
			end
		end
	end

	assign tlb.rtag = s_r.rtag;
	assign tlb.rdata = s_r.rdata;

	////////////////////////////////////////////////////////////////
	// indirect load and read-back, the only path to the entries
	always_comb begin
		s_nxt = s_r;
		e = s_r.ent[tlb.idx];
		if (tlb.wr) begin
			e.vpn = tlb.wtag[`VAMS_T_VPN];
			e.tag = tlb.wtag[`VAMS_T_TAG];
			e.valid = tlb.wtag[`VAMS_T_VALID];
			e.instr = tlb.wtag[`VAMS_T_INSTR];
			e.ppn = tlb.wdata[`VAMS_D_PPN];
			e.size = tlb.wdata[`VAMS_D_SIZE];
			e.cm = tlb.wdata[`VAMS_D_CM];
			e.sp = tlb.wdata[`VAMS_D_SP];
			e.r = tlb.wdata[`VAMS_D_R];
			e.w = tlb.wdata[`VAMS_D_W];
			e.x = tlb.wdata[`VAMS_D_X];
			e.wp = tlb.wdata[`VAMS_D_WP];
			s_nxt.ent[tlb.idx] = e;
		end else if (tlb.rd) begin
			s_nxt.rtag = {e.vpn, e.tag, e.valid, e.instr};
			s_nxt.rdata = {e.ppn, e.size, e.cm, e.sp, e.r, e.w, e.x, e.wp, 1'b0};
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

//--- verif/vams_core_model.sv
// core-side request launcher and answer timing monitor
`timescale 1ns/10ps
module vams_core_model (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic cmd_valid_i,
	input wire logic [31:0] cmd_addr_i,
	input wire logic [1:0] cmd_kind_i,
	input wire logic cmd_special_i,
	input wire logic cmd_super_i,
	input wire logic resp_valid_i,
	output logic req_valid_o,
	output logic [31:0] req_addr_o,
	output logic [1:0] req_kind_o,
	output logic req_special_o,
	output logic supervisor_flag_o,
	output logic [7:0] late_count_o
);
	logic taken_r;

	initial begin
		req_valid_o = 1'b0;
		req_addr_o = 32'h0000_0000;
		req_kind_o = 2'h0;
		req_special_o = 1'b0;
		supervisor_flag_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// launch on the falling edge; an idle address bus wobbles, not a stale copy
	always @(negedge mclk_i) begin
		req_valid_o <= cmd_valid_i;
		req_addr_o <= cmd_valid_i ? cmd_addr_i : ~req_addr_o;
		req_kind_o <= cmd_kind_i;
		req_special_o <= cmd_special_i;
		supervisor_flag_o <= cmd_super_i;
	end
	////////////////////////////////////////////////////////////////
	// each taken request must be answered at exactly the next edge
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			taken_r <= 1'b0;
			late_count_o <= 8'h00;
		end else begin
			taken_r <= req_valid_o;
			if (taken_r !== resp_valid_i)
				late_count_o <= late_count_o + 8'h01;
		end
	end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the address mode select block
`timescale 1ns/10ps
`include "vams_defines.svh"
module tb_top;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cmd_v = 1'b0, cmd_sp = 1'b0, cmd_su = 1'b0;
	logic [31:0] cmd_a = '0;
	logic [1:0] cmd_k = '0;
	logic [7:0] late;
	logic req_valid_i, req_special_i, supervisor_flag_i;
	logic [31:0] req_addr_i;
	logic [1:0] req_kind_i;
	logic [7:0] address_space_tag_i = '0;
	logic translation_enable_i = 1'b0, tlb_wr_i = 1'b0, tlb_rd_i = 1'b0;
	logic [31:0] translation_window_base_i = '0, cache_default_ctrl_i = '0;
	logic [1:0][31:0] sram_window_base_i = '0;
	logic [3:0][31:0] access_window_reg_i = '0;
	logic [4:0] tlb_idx_i = '0;
	logic [31:0] tlb_tag_i = '0, tlb_data_i = '0, cof_target_i = '0, cur_pc_i = '0;
	logic [3:0][39:0] pc_bkpt_i = '0;
	logic [3:0] pc_bkpt_tag_en_i = '0;
	logic [39:0] data_bkpt_i = '0;
	logic data_bkpt_tag_en_i = 1'b0, cof_valid_i = 1'b0, cof_indirect_i = 1'b0;
	logic trace_tag_en_i = 1'b0, pc_resync_request_i = 1'b0;
	logic resp_valid_o, resp_virtual_o, resp_wp_o, resp_fault_o, data_bkpt_hit_o, trace_valid_o;
	logic [31:0] resp_paddr_o, fault_addr_o, tlb_rtag_o, tlb_rdata_o;
	logic [6:0] resp_set_o;
	logic [2:0] resp_src_o;
	logic [1:0] resp_cm_o;
	logic [3:0] fault_status_code_o, pc_bkpt_hit_o;
	logic [39:0] trace_addr_o;
	int bad_count = 0, check_count = 0, cyc = 0;
	logic [31:0] a, w, va;

	vams_top i_vams_top (.*);
	vams_core_model i_vams_core_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_v),
		.cmd_addr_i(cmd_a), .cmd_kind_i(cmd_k), .cmd_special_i(cmd_sp), .cmd_super_i(cmd_su),
		.resp_valid_i(resp_valid_o), .req_valid_o(req_valid_i), .req_addr_o(req_addr_i),
		.req_kind_o(req_kind_i), .req_special_o(req_special_i),
		.supervisor_flag_o(supervisor_flag_i), .late_count_o(late));

	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////////////////////////////
	// hang guard, far above the 130 or so cycles the run needs
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// one request through the core model; returns at the falling edge after the answer
	task automatic req(input logic [31:0] ad, input logic [1:0] k, input logic sp, input logic su);
		@(posedge mclk_i);
		cmd_a = ad;
		cmd_k = k;
		cmd_sp = sp;
		cmd_su = su;
		cmd_v = 1'b1;
		@(posedge mclk_i);
		cmd_v = 1'b0;
		@(negedge mclk_i);
		chk("resp_valid", 1, resp_valid_o);
	endtask

	task automatic exp_phys(input logic [31:0] pa, input logic [2:0] src, input logic virt);
		chk("paddr", pa, resp_paddr_o);
		chk("src", src, resp_src_o);
		chk("virtual", virt, resp_virtual_o);
		chk("fault", 0, resp_fault_o);
	endtask

	task automatic exp_flt(input logic [3:0] fs, input logic [31:0] ad);
		chk("fault", 1, resp_fault_o);
		chk("fault_code", fs, fault_status_code_o);
		chk("fault_addr", ad, fault_addr_o);
	endtask

	// flow-trace request for one cycle; the caller lowers it after the last call
	task automatic trace(input logic ind, input logic rs, input logic ev, input logic [39:0] ea);
		cof_valid_i = 1'b1;
		cof_indirect_i = ind;
		pc_resync_request_i = rs;
		@(negedge mclk_i);
		chk("trace_valid", ev, trace_valid_o);
		if (ev)
			chk("trace_addr", ea, trace_addr_o);
	endtask

	function automatic logic [3:0] fsmiss(input logic [1:0] k);
		case (k)
			`VAMS_KIND_IFETCH: fsmiss = `VAMS_FS_MISS_IFETCH;
			`VAMS_KIND_IEXT: fsmiss = `VAMS_FS_MISS_IEXT;
			`VAMS_KIND_DREAD: fsmiss = `VAMS_FS_MISS_DREAD;
			default: fsmiss = `VAMS_FS_MISS_DWRITE;
		endcase
	endfunction

	// window hit: enable, privilege match, then coarse or fine address mask
	function automatic logic awin_hit(input logic [31:0] ad, input logic [31:0] wr, input logic su);
		logic pok;
		pok = (wr[14:13] == 2'h0) ? !su : (wr[14:13] == 2'h1) ? su : 1'b1;
		if (wr[10])
			awin_hit = (ad[31:24] == wr[31:24]) &&
				((ad[23:20] & ~wr[19:16]) == (wr[23:20] & ~wr[19:16]));
		else
			awin_hit = (ad[31:24] & ~wr[23:16]) == (wr[31:24] & ~wr[23:16]);
		awin_hit = awin_hit && wr[15] && pok;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(26155));
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("rst_valid", 0, resp_valid_o);
		chk("rst_src", 0, resp_src_o);
		chk("rst_trace", 0, trace_valid_o);
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		rstn_i = 1'b1;
		$display("test reset done");
		// untranslated path and special requests
		cache_default_ctrl_i = 32'h0000_0320;
		req(32'h1234_5678, `VAMS_KIND_DREAD, 1'b0, 1'b0);
		exp_phys(32'h1234_5678, 3'h2, 1'b0);
		chk("cm", 2'h3, resp_cm_o);
		chk("wp", 1, resp_wp_o);
		translation_enable_i = 1'b1;
		req(32'h8000_0004, `VAMS_KIND_DWRITE, 1'b1, 1'b1);
		exp_phys(32'h8000_0004, 3'h1, 1'b0);
		chk("cm", `VAMS_CM_NOCACHE, resp_cm_o);
		$display("test physical done");
		// translation window: supervisor data only, else falls through to a miss
		translation_window_base_i = 32'h7700_0001;
		req(32'h7700_0010, `VAMS_KIND_DREAD, 1'b0, 1'b1);
		exp_phys(32'h7700_0010, 3'h3, 1'b0);
		req(32'h7700_0010, `VAMS_KIND_DREAD, 1'b0, 1'b0);
		exp_flt(`VAMS_FS_MISS_DREAD, 32'h7700_0010);
		req(32'h7700_0010, `VAMS_KIND_IFETCH, 1'b0, 1'b1);
		exp_flt(`VAMS_FS_MISS_IFETCH, 32'h7700_0010);
		translation_window_base_i = '0;
		// sram window outranks an overlapping access window
		sram_window_base_i[0] = 32'h4000_0101;
		access_window_reg_i[0] = 32'h4000_c020;
		req(32'h4000_0040, `VAMS_KIND_DREAD, 1'b0, 1'b0);
		exp_phys(32'h4000_0040, 3'h4, 1'b0);
		chk("wp", 1, resp_wp_o);
		req(32'h4000_2000, `VAMS_KIND_DWRITE, 1'b0, 1'b0);
		exp_phys(32'h4000_2000, 3'h5, 1'b0);
		chk("cm", 2'h1, resp_cm_o);
		sram_window_base_i = '0;
		$display("test priority done");
		// access window hit function: three corners then random fields
		for (int i = 0; i < 43; i++) begin
			a = (i < 3) ? ((i == 1) ? 32'h4060_0000 : 32'h4050_0000) : $urandom;
			w = (i < 3) ? 32'h4050_8400 : $urandom;
			if (i >= 3 && i % 2 == 0)
				w[31:24] = a[31:24];
			cmd_su = (i < 3) ? (i == 2) : $urandom;
			access_window_reg_i[0] = w;
			req(a, {1'b1, 1'(i)}, 1'b0, cmd_su);
			if (awin_hit(a, w, cmd_su)) begin
				exp_phys(a, 3'h5, 1'b0);
				chk("cm", w[6:5], resp_cm_o);
			end else begin
				exp_flt(fsmiss({1'b1, 1'(i)}), a);
			end
		end
		access_window_reg_i = '0;
		$display("test access window done");
		// every access kind misses with its own code
		for (int k = 0; k < 4; k++) begin
			req(32'h0900_0000 + 32'(k * 4), 2'(k), 1'b0, 1'b1);
			exp_flt(fsmiss(2'(k)), 32'h0900_0000 + 32'(k * 4));
		end
		$display("test miss codes done");
		// load one data entry; page bit 10 equal on both sides keeps cache sets clean
		tlb_idx_i = 5'h03;
		tlb_tag_i = {22'h000123, 8'h3c, 1'b1, 1'b0};
		tlb_data_i = {22'h0002a5, 2'h0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		tlb_wr_i = 1'b1;
		@(negedge mclk_i);
		tlb_wr_i = 1'b0;
		tlb_rd_i = 1'b1;
		@(negedge mclk_i);
		tlb_rd_i = 1'b0;
		chk("rtag", tlb_tag_i, tlb_rtag_o);
		chk("rdata", tlb_data_i, tlb_rdata_o);
		address_space_tag_i = 8'h3c;
		va = {22'h000123, 10'h1f4};
		req(va, `VAMS_KIND_DREAD, 1'b0, 1'b0);
		exp_phys({22'h0002a5, 10'h1f4}, 3'h6, 1'b1);
		chk("cm", 2'h1, resp_cm_o);
		chk("set", va[10:4], resp_set_o);
		req(va, `VAMS_KIND_DWRITE, 1'b0, 1'b0);
		exp_flt(`VAMS_FS_VIOL, va);
		$display("test translation done");
		// breakpoints with tag compare, then flow trace and resync
		translation_enable_i = 1'b0;
		pc_bkpt_i[1] = {8'h5a, 32'h1000_0000};
		pc_bkpt_tag_en_i = 4'h2;
		data_bkpt_i = {8'h5a, 32'h2000_0008};
		data_bkpt_tag_en_i = 1'b1;
		for (int t = 0; t < 2; t++) begin
			address_space_tag_i = 8'h5a + 8'(t);
			req(32'h1000_0000, `VAMS_KIND_IFETCH, 1'b0, 1'b1);
			chk("pc_bkpt", (t == 0) ? 4'h2 : 4'h0, pc_bkpt_hit_o);
			req(32'h2000_0008, `VAMS_KIND_DREAD, 1'b0, 1'b1);
			chk("data_bkpt", t == 0, data_bkpt_hit_o);
		end
		trace_tag_en_i = 1'b1;
		cof_target_i = 32'h0bad_0040;
		cur_pc_i = 32'h0000_1234;
		trace(1'b1, 1'b0, 1'b1, {8'h5b, 32'h0bad_0040});
		trace(1'b0, 1'b0, 1'b0, '0);
		trace(1'b0, 1'b1, 1'b1, {8'h5b, 32'h0000_1234});
		cof_valid_i = 1'b0;
		pc_resync_request_i = 1'b0;
		$display("test debug done");
		chk("late_answers", 0, late);
		summarize();
	end
endmodule
